// [rtl/psm_pkg.sv]
// constants and carrier types for the port s / port m pin control block
`default_nettype none
package psm_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PS_PULL_EN   = 8'h0c;
    localparam logic [7:0] IDX_PS_PULL_POL  = 8'h0d;
    localparam logic [7:0] IDX_PS_OD_SEL    = 8'h0e;
    localparam logic [7:0] IDX_PM_OUT_DATA  = 8'h10;
    localparam logic [7:0] IDX_PM_PIN_LEVEL = 8'h11;
    localparam logic [7:0] IDX_PM_DIR       = 8'h12;
    localparam logic [7:0] IDX_PM_DRIVE     = 8'h13;
    localparam int unsigned ADDR_W          = 12;
    // reset values
    localparam logic [7:0] RST_PS_PULL_EN   = 8'h0f;
    localparam logic [7:0] RST_PS_PULL_POL  = 8'h00;
    localparam logic [7:0] RST_PS_OD_SEL    = 8'h00;
    localparam logic [7:0] RST_PM_OUT_DATA  = 8'h00;
    localparam logic [7:0] RST_PM_DIR       = 8'h00;
    localparam logic [7:0] RST_PM_DRIVE     = 8'h00;
    // port m pin positions of the peripheral channels
    localparam int unsigned PM_CAN_RX_BIT   = 0;
    localparam int unsigned PM_CAN_TX_BIT   = 1;
    localparam int unsigned PM_SPI_LO_BIT   = 2;
    localparam int unsigned PM_SPI_PINS     = 4;
    // axi responses
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;
    // register decode result
    typedef enum logic [7:0] {
        PSM_REG_NONE   = 8'h00,
        PSM_REG_PS_EN  = 8'h01,
        PSM_REG_PS_POL = 8'h02,
        PSM_REG_PS_OD  = 8'h04,
        PSM_REG_PM_DAT = 8'h08,
        PSM_REG_PM_LVL = 8'h10,
        PSM_REG_PM_DIR = 8'h20,
        PSM_REG_PM_DRV = 8'h40
    } psm_reg_e;
    // drive decision for one pin
    typedef struct packed {
        logic oe;
        logic dout;
    } psm_drv_s;
endpackage
`default_nettype wire

// [rtl/psm_pin_ctrl.sv]
// pin control for the four-bit serial port s and six-bit port m, axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - pull active on input pin, or on open-drain pin with pull-up
// - pull enable ignored on push-pull output
// - reset: port s pulls enabled, pull-up
// - polarity 0 gives pull-up, input or open-drain
// - polarity 1 gives pull-down, input only
// - open-drain drives low only, else push-pull
// - open-drain select ignored on inputs
// - data read: latch if output, pin if input
// - pins 5..2 follow spi status bits
// - level register reads pins, ignores writes
// - direction bit 0 input, 1 output
// - enabled spi or can decides pin direction
// - tx channel forces output, rx forces input
// - disabled channel returns control to direction bit
// - readback settles within three bus cycles
// - drive bit 0 full, 1 reduced
// - drive bit ignored on input pins
module psm_pin_ctrl #(
    parameter int unsigned PS_WIDTH = 4,
    parameter int unsigned PM_WIDTH = 6
) (
    // clock and reset
    input  wire logic                          REF_CLK,
    input  wire logic                          RST,
    // axi4-lite write address
    input  wire logic [psm_pkg::ADDR_W-1:0]    S_AXI_AWADDR,
    input  wire logic [2:0]                    S_AXI_AWPROT,
    input  wire logic                          S_AXI_AWVALID,
    output logic                               S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0]                   S_AXI_WDATA,
    input  wire logic [3:0]                    S_AXI_WSTRB,
    input  wire logic                          S_AXI_WVALID,
    output logic                               S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]                         S_AXI_BRESP,
    output logic                               S_AXI_BVALID,
    input  wire logic                          S_AXI_BREADY,
    // axi4-lite read address
    input  wire logic [psm_pkg::ADDR_W-1:0]    S_AXI_ARADDR,
    input  wire logic [2:0]                    S_AXI_ARPROT,
    input  wire logic                          S_AXI_ARVALID,
    output logic                               S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0]                        S_AXI_RDATA,
    output logic [1:0]                         S_AXI_RRESP,
    output logic                               S_AXI_RVALID,
    input  wire logic                          S_AXI_RREADY,
    // port s state from the port s data/direction logic
    input  wire logic [PS_WIDTH-1:0]           PS_DIR,
    input  wire logic [PS_WIDTH-1:0]           PS_DATA,
    // port s pad controls
    output logic [PS_WIDTH-1:0]                PS_PAD_OUT,
    output logic [PS_WIDTH-1:0]                PS_PAD_OE,
    output logic [PS_WIDTH-1:0]                PS_PULL_UP,
    output logic [PS_WIDTH-1:0]                PS_PULL_DOWN,
    // port m pads
    input  wire logic [PM_WIDTH-1:0]           PM_PAD_IN,
    output logic [PM_WIDTH-1:0]                PM_PAD_OUT,
    output logic [PM_WIDTH-1:0]                PM_PAD_OE,
    output logic [PM_WIDTH-1:0]                PM_REDUCED_DRIVE,
    // can controller channels on port m
    input  wire logic                          CAN_RX_EN,
    input  wire logic                          CAN_TX_EN,
    input  wire logic                          CAN_TXD,
    // spi pin status on port m upper pins
    input  wire logic [3:0]                    SPI_PIN_EN,
    input  wire logic [3:0]                    SPI_PIN_OUT,
    input  wire logic [3:0]                    SPI_PIN_DO
);

    // refuse widths the fixed pin mapping cannot serve
    initial begin
        if (PS_WIDTH < 1 || PS_WIDTH > 8 || PM_WIDTH < 6 || PM_WIDTH > 8) begin
            $error("psm_pin_ctrl: unsupported port width");
        end
    end

    // register index decode, shared by read and write paths
    function automatic psm_pkg::psm_reg_e reg_decode(input logic [psm_pkg::ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        reg_decode = psm_pkg::PSM_REG_NONE;
        if (addr[1:0] == 2'h0 && addr[psm_pkg::ADDR_W-1:10] == '0) begin
            case (idx)
                psm_pkg::IDX_PS_PULL_EN:   reg_decode = psm_pkg::PSM_REG_PS_EN;
                psm_pkg::IDX_PS_PULL_POL:  reg_decode = psm_pkg::PSM_REG_PS_POL;
                psm_pkg::IDX_PS_OD_SEL:    reg_decode = psm_pkg::PSM_REG_PS_OD;
                psm_pkg::IDX_PM_OUT_DATA:  reg_decode = psm_pkg::PSM_REG_PM_DAT;
                psm_pkg::IDX_PM_PIN_LEVEL: reg_decode = psm_pkg::PSM_REG_PM_LVL;
                psm_pkg::IDX_PM_DIR:       reg_decode = psm_pkg::PSM_REG_PM_DIR;
                psm_pkg::IDX_PM_DRIVE:     reg_decode = psm_pkg::PSM_REG_PM_DRV;
                default:                   reg_decode = psm_pkg::PSM_REG_NONE;
            endcase
        end
    endfunction

    // control registers
    logic [PS_WIDTH-1:0]        ps_pull_en_ff;
    logic [PS_WIDTH-1:0]        ps_pull_pol_ff;
    logic [PS_WIDTH-1:0]        ps_od_sel_ff;
    logic [PM_WIDTH-1:0]        pm_out_data_ff;
    logic [PM_WIDTH-1:0]        pm_dir_ff;
    logic [PM_WIDTH-1:0]        pm_drive_ff;
    // bus slave state
    logic                       awrdy_ff;
    logic                       wrdy_ff;
    logic                       aw_got_ff;
    logic                       w_got_ff;
    logic [psm_pkg::ADDR_W-1:0] awaddr_ff;
    logic [7:0]                 wdata_ff;
    logic                       wlane0_ff;
    logic                       bvalid_ff;
    logic [1:0]                 bresp_ff;
    logic                       arrdy_ff;
    logic                       rvalid_ff;
    logic [31:0]                rdata_ff;
    logic [1:0]                 rresp_ff;
    // pin synchroniser and effective pin state
    logic [PM_WIDTH-1:0]        pm_sync1_ff;
    logic [PM_WIDTH-1:0]        pm_sync2_ff;
    psm_pkg::psm_drv_s          pm_drv [PM_WIDTH];
    logic [PM_WIDTH-1:0]        pm_oe_eff;
    logic [PM_WIDTH-1:0]        pm_do_eff;
    logic [PM_WIDTH-1:0]        pm_dir_eff_ff;
    // write and read handshake terms
    logic                       aw_take;
    logic                       w_take;
    logic                       do_wr;
    logic                       nxt_aw_got;
    logic                       nxt_w_got;
    logic                       nxt_bvalid;
    logic                       ar_take;
    logic                       nxt_rvalid;
    psm_pkg::psm_reg_e          wr_sel;
    psm_pkg::psm_reg_e          rd_sel;
    logic [7:0]                 nxt_rdata;
    logic [PM_WIDTH-1:0]        pm_data_view;

    // write path: address and data are taken independently, paired, then answered
    assign aw_take    = S_AXI_AWVALID & awrdy_ff;
    assign w_take     = S_AXI_WVALID & wrdy_ff;
    assign do_wr      = aw_got_ff & w_got_ff & ~bvalid_ff;
    assign nxt_aw_got = do_wr ? 1'b0 : (aw_got_ff | aw_take);
    assign nxt_w_got  = do_wr ? 1'b0 : (w_got_ff | w_take);
    assign nxt_bvalid = do_wr | (bvalid_ff & ~S_AXI_BREADY);
    assign wr_sel     = reg_decode(awaddr_ff);

    // read path: one cycle from address acceptance to data
    assign ar_take    = S_AXI_ARVALID & arrdy_ff;
    assign nxt_rvalid = ar_take | (rvalid_ff & ~S_AXI_RREADY);
    assign rd_sel     = reg_decode(S_AXI_ARADDR);

    // write channel handshake registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            awrdy_ff  <= 1'b0;
            wrdy_ff   <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= psm_pkg::RESP_OKAY;
        end else begin
            awrdy_ff  <= ~nxt_aw_got & ~nxt_bvalid;
            wrdy_ff   <= ~nxt_w_got & ~nxt_bvalid;
            aw_got_ff <= nxt_aw_got;
            w_got_ff  <= nxt_w_got;
            bvalid_ff <= nxt_bvalid;
            if (do_wr) begin
                bresp_ff <= (wr_sel == psm_pkg::PSM_REG_NONE) ? psm_pkg::RESP_SLVERR
                                                              : psm_pkg::RESP_OKAY;
            end
        end
    end

    // captured write address and data
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            awaddr_ff <= '0;
            wdata_ff  <= 8'h00;
            wlane0_ff <= 1'b0;
        end else begin
            if (aw_take) begin
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (w_take) begin
                wdata_ff  <= S_AXI_WDATA[7:0];
                wlane0_ff <= S_AXI_WSTRB[0];
            end
        end
    end

    // control registers; a write lands on the edge after address and data pair up
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ps_pull_en_ff  <= psm_pkg::RST_PS_PULL_EN[PS_WIDTH-1:0];
            ps_pull_pol_ff <= psm_pkg::RST_PS_PULL_POL[PS_WIDTH-1:0];
            ps_od_sel_ff   <= psm_pkg::RST_PS_OD_SEL[PS_WIDTH-1:0];
            pm_out_data_ff <= psm_pkg::RST_PM_OUT_DATA[PM_WIDTH-1:0];
            pm_dir_ff      <= psm_pkg::RST_PM_DIR[PM_WIDTH-1:0];
            pm_drive_ff    <= psm_pkg::RST_PM_DRIVE[PM_WIDTH-1:0];
        end else if (do_wr && wlane0_ff) begin
            // the pin level register takes no write
            case (wr_sel)
                psm_pkg::PSM_REG_PS_EN:  ps_pull_en_ff  <= wdata_ff[PS_WIDTH-1:0];
                psm_pkg::PSM_REG_PS_POL: ps_pull_pol_ff <= wdata_ff[PS_WIDTH-1:0];
                psm_pkg::PSM_REG_PS_OD:  ps_od_sel_ff   <= wdata_ff[PS_WIDTH-1:0];
                psm_pkg::PSM_REG_PM_DAT: pm_out_data_ff <= wdata_ff[PM_WIDTH-1:0];
                psm_pkg::PSM_REG_PM_DIR: pm_dir_ff      <= wdata_ff[PM_WIDTH-1:0];
                psm_pkg::PSM_REG_PM_DRV: pm_drive_ff    <= wdata_ff[PM_WIDTH-1:0];
                default:                 pm_dir_ff      <= pm_dir_ff;
            endcase
        end
    end

    // two-stage synchroniser on the port m pins
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pm_sync1_ff <= '0;
            pm_sync2_ff <= '0;
        end else begin
            pm_sync1_ff <= PM_PAD_IN;
            pm_sync2_ff <= pm_sync1_ff;
        end
    end

    // per-pin direction: peripheral channel overrides, else the direction bit
    genvar gi;
    generate
        for (gi = 0; gi < PM_WIDTH; gi++) begin : g_pm_pin
            if (gi == psm_pkg::PM_CAN_RX_BIT) begin : g_can_rx
                assign pm_drv[gi].oe   = CAN_RX_EN ? 1'b0 : pm_dir_ff[gi];
                assign pm_drv[gi].dout = pm_out_data_ff[gi];
            end else if (gi == psm_pkg::PM_CAN_TX_BIT) begin : g_can_tx
                assign pm_drv[gi].oe   = CAN_TX_EN ? 1'b1 : pm_dir_ff[gi];
                assign pm_drv[gi].dout = CAN_TX_EN ? CAN_TXD : pm_out_data_ff[gi];
            end else if (gi < psm_pkg::PM_SPI_LO_BIT + psm_pkg::PM_SPI_PINS) begin : g_spi
                localparam int unsigned SI = gi - psm_pkg::PM_SPI_LO_BIT;
                // spi status decides the pin while it owns it
                assign pm_drv[gi].oe   = SPI_PIN_EN[SI] ? SPI_PIN_OUT[SI]
                                                        : pm_dir_ff[gi];
                assign pm_drv[gi].dout = SPI_PIN_EN[SI] ? SPI_PIN_DO[SI]
                                                        : pm_out_data_ff[gi];
            end else begin : g_plain
                assign pm_drv[gi].oe   = pm_dir_ff[gi];
                assign pm_drv[gi].dout = pm_out_data_ff[gi];
            end
            assign pm_oe_eff[gi] = pm_drv[gi].oe;
            assign pm_do_eff[gi] = pm_drv[gi].dout;
        end
    endgenerate

    // data register view: latch for output pins, synchronised pin for inputs
    assign pm_data_view = (pm_dir_eff_ff & pm_out_data_ff)
                        | (~pm_dir_eff_ff & pm_sync2_ff);

    // read data mux
    always_comb begin
        nxt_rdata = 8'h00;
        case (rd_sel)
            psm_pkg::PSM_REG_PS_EN:  nxt_rdata[PS_WIDTH-1:0] = ps_pull_en_ff;
            psm_pkg::PSM_REG_PS_POL: nxt_rdata[PS_WIDTH-1:0] = ps_pull_pol_ff;
            psm_pkg::PSM_REG_PS_OD:  nxt_rdata[PS_WIDTH-1:0] = ps_od_sel_ff;
            psm_pkg::PSM_REG_PM_DAT: nxt_rdata[PM_WIDTH-1:0] = pm_data_view;
            psm_pkg::PSM_REG_PM_LVL: nxt_rdata[PM_WIDTH-1:0] = pm_sync2_ff;
            psm_pkg::PSM_REG_PM_DIR: nxt_rdata[PM_WIDTH-1:0] = pm_dir_ff;
            psm_pkg::PSM_REG_PM_DRV: nxt_rdata[PM_WIDTH-1:0] = pm_drive_ff;
            default:                 nxt_rdata = 8'h00;
        endcase
    end

    // read channel registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            arrdy_ff  <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= psm_pkg::RESP_OKAY;
        end else begin
            arrdy_ff  <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= {24'h000000, nxt_rdata};
                rresp_ff <= (rd_sel == psm_pkg::PSM_REG_NONE) ? psm_pkg::RESP_SLVERR
                                                              : psm_pkg::RESP_OKAY;
            end
        end
    end

    // port s pad controls from pull and open-drain settings
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PS_PAD_OUT   <= '0;
            PS_PAD_OE    <= '0;
            PS_PULL_UP   <= '0;
            PS_PULL_DOWN <= '0;
        end else begin
            // open-drain output drives only the low level
            PS_PAD_OUT   <= PS_DATA & ~ps_od_sel_ff;
            PS_PAD_OE    <= PS_DIR & ~(ps_od_sel_ff & PS_DATA);
            // pull-up on inputs and open-drain outputs, never push-pull
            PS_PULL_UP   <= ps_pull_en_ff & ~ps_pull_pol_ff
                          & (~PS_DIR | ps_od_sel_ff);
            // pull-down on inputs only
            PS_PULL_DOWN <= ps_pull_en_ff & ps_pull_pol_ff & ~PS_DIR;
        end
    end

    // port m pad controls
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PM_PAD_OUT       <= '0;
            PM_PAD_OE        <= '0;
            PM_REDUCED_DRIVE <= '0;
            pm_dir_eff_ff    <= '0;
        end else begin
            PM_PAD_OUT       <= pm_do_eff;
            PM_PAD_OE        <= pm_oe_eff;
            PM_REDUCED_DRIVE <= pm_drive_ff & pm_oe_eff;
            pm_dir_eff_ff    <= pm_oe_eff;
        end
    end

    // bus outputs straight from their flops
    assign S_AXI_AWREADY = awrdy_ff;
    assign S_AXI_WREADY  = wrdy_ff;
    assign S_AXI_BVALID  = bvalid_ff;
    assign S_AXI_BRESP   = bresp_ff;
    assign S_AXI_ARREADY = arrdy_ff;
    assign S_AXI_RVALID  = rvalid_ff;
    assign S_AXI_RDATA   = rdata_ff;
    assign S_AXI_RRESP   = rresp_ff;

endmodule
`default_nettype wire

// [verification/psm_pin_partner.sv]
// external pin model for port m: pad drive wins, otherwise the outside level shows
`timescale 1ns/1ps
`default_nettype none
module psm_pin_partner (
    // pad side
    input  wire logic [5:0] oe,
    input  wire logic [5:0] dout,
    // outside driver level on released pins
    input  wire logic [5:0] ext,
    output logic [5:0]      pin
);
    // resolve each wire from the pad enable and the outside driver
    assign pin = (oe & dout) | (~oe & ext);
endmodule
`default_nettype wire

// [verification/psm_pin_ctrl_chk.sv]
// assertion checker for the port s and port m pin control block
`timescale 1ns/1ps
`default_nettype none
module psm_pin_ctrl_chk #(
    parameter int unsigned PS_WIDTH = 4,
    parameter int unsigned PM_WIDTH = 6
) (
    // clock and reset
    input wire logic                REF_CLK,
    input wire logic                RST,
    // bus handshakes
    input wire logic                S_AXI_AWVALID,
    input wire logic                S_AXI_AWREADY,
    input wire logic [1:0]          S_AXI_BRESP,
    input wire logic                S_AXI_BVALID,
    input wire logic                S_AXI_BREADY,
    // port s
    input wire logic [PS_WIDTH-1:0] PS_DIR,
    input wire logic [PS_WIDTH-1:0] PS_DATA,
    input wire logic [PS_WIDTH-1:0] PS_PAD_OUT,
    input wire logic [PS_WIDTH-1:0] PS_PAD_OE,
    input wire logic [PS_WIDTH-1:0] PS_PULL_UP,
    input wire logic [PS_WIDTH-1:0] PS_PULL_DOWN,
    // port m
    input wire logic [PM_WIDTH-1:0] PM_PAD_OUT,
    input wire logic [PM_WIDTH-1:0] PM_PAD_OE,
    input wire logic [PM_WIDTH-1:0] PM_REDUCED_DRIVE,
    input wire logic                CAN_RX_EN,
    input wire logic                CAN_TX_EN,
    input wire logic                CAN_TXD,
    input wire logic [3:0]          SPI_PIN_EN,
    input wire logic [3:0]          SPI_PIN_OUT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // port s pads follow their inputs one edge later
    chk_pull_excl: assert property ((PS_PULL_UP & PS_PULL_DOWN) == '0)
        else $error("pull-up and pull-down on together");
    chk_pd_input: assert property (!$past(RST) |-> (PS_PULL_DOWN & $past(PS_DIR)) == '0)
        else $error("pull-down on an output pin");
    chk_pp_nopull: assert property ((PS_PAD_OE & PS_PAD_OUT & PS_PULL_UP) == '0)
        else $error("pull-up on a push-pull output");
    chk_od_high: assert property (!$past(RST) |-> (PS_PAD_OUT & ~$past(PS_DATA)) == '0)
        else $error("pad drives high without data");
    chk_od_low: assert property (!$past(RST) |-> ($past(PS_DIR) & ~$past(PS_DATA) & ~PS_PAD_OE) == '0)
        else $error("output low not driven");
    chk_od_input: assert property (!$past(RST) |-> (PS_PAD_OE & ~$past(PS_DIR)) == '0)
        else $error("input pin driven");
    // port m channel overrides and reduced drive
    chk_can_rx: assert property (!$past(RST) && $past(CAN_RX_EN) |-> !PM_PAD_OE[0])
        else $error("can receive pin driven");
    chk_can_tx: assert property (CAN_TX_EN |=> PM_PAD_OE[1] && PM_PAD_OUT[1] == $past(CAN_TXD))
        else $error("can transmit pin not driven");
    chk_spi_dir: assert property (!$past(RST) |->
        (PM_PAD_OE[5:2] & $past(SPI_PIN_EN)) == ($past(SPI_PIN_EN) & $past(SPI_PIN_OUT)))
        else $error("spi pin direction wrong");
    chk_rd_input: assert property ((PM_REDUCED_DRIVE & ~PM_PAD_OE) == '0)
        else $error("reduced drive on input pin");
    // bus response holding and write address acceptance
    chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    chk_aw_busy: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("second write address taken");
endmodule
bind psm_pin_ctrl psm_pin_ctrl_chk #(.PS_WIDTH(PS_WIDTH), .PM_WIDTH(PM_WIDTH)) u_chk (
    .REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .PS_DIR(PS_DIR), .PS_DATA(PS_DATA), .PS_PAD_OUT(PS_PAD_OUT), .PS_PAD_OE(PS_PAD_OE),
    .PS_PULL_UP(PS_PULL_UP), .PS_PULL_DOWN(PS_PULL_DOWN), .PM_PAD_OUT(PM_PAD_OUT),
    .PM_PAD_OE(PM_PAD_OE), .PM_REDUCED_DRIVE(PM_REDUCED_DRIVE), .CAN_RX_EN(CAN_RX_EN),
    .CAN_TX_EN(CAN_TX_EN), .CAN_TXD(CAN_TXD), .SPI_PIN_EN(SPI_PIN_EN), .SPI_PIN_OUT(SPI_PIN_OUT));
`default_nettype wire

// [verification/tb_psm_pin_ctrl.sv]
// self-checking bench: random register traffic and pin stimulus against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb_psm_pin_ctrl;
    logic        REF_CLK = 1'b0;
    logic        RST = 1'b1;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  ps_dir = '0, ps_data = '0, ps_out, ps_oe, ps_pu, ps_pd;
    logic [3:0]  spi_en = '0, spi_dir = '0, spi_do = '0;
    logic        can_rx = 1'b0, can_tx = 1'b0, can_txd = 1'b0;
    logic [5:0]  pm_ext = '0, pm_pin, pm_out, pm_oe, pm_rd, d, o, p;
    logic [31:0] seed = 32'ha972, v, q;
    logic [7:0]  idx [7] = '{psm_pkg::IDX_PS_PULL_EN, psm_pkg::IDX_PS_PULL_POL,
        psm_pkg::IDX_PS_OD_SEL, psm_pkg::IDX_PM_OUT_DATA, psm_pkg::IDX_PM_PIN_LEVEL,
        psm_pkg::IDX_PM_DIR, psm_pkg::IDX_PM_DRIVE};
    int          mr [7] = '{32'h0f, 0, 0, 0, 0, 0, 0};
    int          error_cnt = 0, n_checks = 0, i, k;
    // bus clock, 100 ns period
    always #50 REF_CLK = ~REF_CLK;
    // device under test and the pins beyond it
    psm_pin_ctrl u_dut (.REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PS_DIR(ps_dir), .PS_DATA(ps_data), .PS_PAD_OUT(ps_out), .PS_PAD_OE(ps_oe),
        .PS_PULL_UP(ps_pu), .PS_PULL_DOWN(ps_pd), .PM_PAD_IN(pm_pin), .PM_PAD_OUT(pm_out),
        .PM_PAD_OE(pm_oe), .PM_REDUCED_DRIVE(pm_rd), .CAN_RX_EN(can_rx), .CAN_TX_EN(can_tx),
        .CAN_TXD(can_txd), .SPI_PIN_EN(spi_en), .SPI_PIN_OUT(spi_dir), .SPI_PIN_DO(spi_do));
    psm_pin_partner u_pins (.oe(pm_oe), .dout(pm_out), .ext(pm_ext), .pin(pm_pin));
    // verdict and end of run
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // compare one result
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // axi4-lite write of one word, waits for the response
    task automatic wr(input logic [11:0] a, input logic [7:0] dat, output logic [1:0] rs);
        int n;
        @(posedge REF_CLK);
        awaddr <= a;
        wdata <= {24'h0, dat};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        rs = 2'h3;
        for (n = 0; n < 40 && rs === 2'h3; n++) begin
            @(posedge REF_CLK);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
            end
        end
        if (rs === 2'h3) begin
            error_cnt++;
            end_sim();
        end
    endtask
    // axi4-lite read of one word
    task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rs);
        int n;
        @(posedge REF_CLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rs = 2'h3;
        for (n = 0; n < 40 && rs === 2'h3; n++) begin
            @(posedge REF_CLK);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rs = rresp;
                dat = rdata;
                rready <= 1'b0;
            end
        end
        if (rs === 2'h3) begin
            error_cnt++;
            end_sim();
        end
    endtask
    // model: effective direction, pin levels and expected readback of register j
    function automatic logic [31:0] model(input int j);
        d = mr[5][5:0];
        o = mr[3][5:0];
        if (can_rx) d[0] = 1'b0;
        if (can_tx) {d[1], o[1]} = {1'b1, can_txd};
        for (int b = 0; b < 4; b++)
            if (spi_en[b]) {d[b+2], o[b+2]} = {spi_dir[b], spi_do[b]};
        p = (d & o) | (~d & pm_ext);
        if (j == 3) return {26'h0, (d & mr[3][5:0]) | (~d & p)};
        if (j == 4) return {26'h0, p};
        return mr[j];
    endfunction
    // main sequence
    initial begin
        repeat (8) @(posedge REF_CLK);
        RST <= 1'b0;
        for (i = 0; i < 7; i++) begin
            rd({2'b0, idx[i], 2'b0}, q, r);
            chk("reset value", model(i), q);
        end
        chk("reset pull-up", {28'h0, ~ps_dir}, {28'h0, ps_pu});
        for (k = 0; k < 42; k++) begin
            i = k % 7;
            seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
            v = seed;
            wr({2'b0, idx[i], 2'b0}, v[7:0], r);
            chk("write resp", 32'(psm_pkg::RESP_OKAY), 32'(r));
            if (i != 4) mr[i] = {24'h0, v[7:0] & (i < 3 ? 8'h0f : 8'h3f)};
            {ps_dir, ps_data, spi_en, spi_dir} <= v[23:8];
            {spi_do, can_rx, can_tx, can_txd} <= {v[30:24]};
            pm_ext <= v[5:0] ^ v[31:26];
            repeat (4) @(posedge REF_CLK);
            chk("ps pad out", {28'h0, ps_data & ~mr[2][3:0]}, {28'h0, ps_out});
            chk("ps pad oe", {28'h0, ps_dir & ~(mr[2][3:0] & ps_data)}, {28'h0, ps_oe});
            chk("ps pull up", {28'h0, mr[0][3:0] & ~mr[1][3:0] & (~ps_dir | mr[2][3:0])},
                {28'h0, ps_pu});
            chk("ps pull down", {28'h0, mr[0][3:0] & mr[1][3:0] & ~ps_dir}, {28'h0, ps_pd});
            q = model(i);
            chk("pm pad oe", {26'h0, d}, {26'h0, pm_oe});
            chk("pm pad out", {26'h0, o & d}, {26'h0, pm_out & pm_oe});
            chk("pm reduced", {26'h0, mr[6][5:0] & d}, {26'h0, pm_rd});
            rd({2'b0, idx[i], 2'b0}, v, r);
            chk("readback", q, v);
            rd({2'b0, psm_pkg::IDX_PM_PIN_LEVEL, 2'b0}, v, r);
            chk("pin level", model(4), v);
        end
        wr(12'h050, 8'hff, r);
        chk("unmapped write", 32'(psm_pkg::RESP_SLVERR), 32'(r));
        rd(12'h031, v, r);
        chk("misaligned read", {30'h0, psm_pkg::RESP_SLVERR}, {v[29:0], r});
        end_sim();
    end
endmodule
`default_nettype wire
